/* fingerprint_scan_regs.svh */
`ifndef FINGERPRINT_SCAN_REGS_SVH
`define FINGERPRINT_SCAN_REGS_SVH
`define IDX_ROW_START_HIGH   8'h00
`define IDX_ROW_START_LOW    8'h01
`define IDX_COL_FIRST        8'h02
`define IDX_ROW_LAST_HIGH    8'h03
`define IDX_ROW_LAST_LOW     8'h04
`define IDX_COL_LAST         8'h05
`define IDX_DRAIN_TIME       8'h06
`define IDX_DRAIN_CURRENT    8'h07
`define IDX_CAPTURE_COMMAND  8'h08
`define IDX_POWER_CLOCK      8'h09
`define IDX_PORT_OUT         8'h0A
`define IDX_CAPTURE_STATUS   8'h0B
`define IDX_AMP_LEVEL        8'h0C
`define IDX_IRQ_CONTROL      8'h0D
`define IDX_IRQ_STATUS       8'h0E
`define IDX_FINGER_TRIP      8'h0F
`define IDX_CHIP_ID_HIGH     8'h10
`define IDX_CHIP_ID_LOW      8'h11
`define IDX_FACTORY_TEST     8'h12
`define CMD_AIN_BIT          3
`define CMD_WINDOW_BIT       2
`define CMD_FULL_BIT         1
`define CMD_LINE_BIT         0
`define PCC_READY_BIT        5
`define PCC_AUTO_BIT         2
`define REG_RESET            8'h00
`define PCC_LOW_RESET        5'h00
`define IMG_ROW_LAST         9'h12B
`define IMG_COL_LAST         8'hFF
`define MODE_USB_EXT_ROM     2'h3
`define ROM_READ_CMD         8'h03
`define ROM_HEADER_LAST      9'h002
`define CLK_KHZ              125000
`define SCK_MAX_KHZ          1000
`define SCK_HALF             ((`CLK_KHZ + 2 * `SCK_MAX_KHZ - 1) / (2 * `SCK_MAX_KHZ))
`define FIRST_VALID_BASE     28
`define NEXT_VALID_MAX       6
`define FIFO_WIDTH           8
`define FIFO_DEPTH           16
`endif

/* fingerprint_scan_pkg.sv */
package fingerprint_scan_pkg;
  typedef enum logic [3:0] {
    SCAN_IDLE  = 4'h1,
    SCAN_DRAIN = 4'h2,
    SCAN_CONV  = 4'h4,
    SCAN_HOLD  = 4'h8
  } scan_state_t;
  typedef enum logic [1:0] {
    ROM_IDLE = 2'h1,
    ROM_XFER = 2'h2
  } rom_state_t;
endpackage : fingerprint_scan_pkg

/* fingerprint_image_scan_control.sv */
`include "fingerprint_scan_regs.svh"

module scan_result_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } fifo_state_t;
  fifo_state_t q;
  fifo_state_t next_q;
  logic        doPush;
  logic        doPop;

  assign inReady  = (q.count != (AW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData  = q.mem[q.rdPtr];

  always_comb begin
    next_q = q;
    doPush = inValid && inReady;
    doPop  = outValid && outReady;
    // A flush also drops a push of the same cycle, since that word belongs to the old scan.
    if (flush) begin
      next_q.wrPtr = '0;
      next_q.rdPtr = '0;
      next_q.count = '0;
    end else begin
      if (doPush) begin
        next_q.mem[q.wrPtr] = inData;
        next_q.wrPtr        = q.wrPtr + 1'b1;
      end
      if (doPop) begin
        next_q.rdPtr = q.rdPtr + 1'b1;
      end
      next_q.count = q.count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : scan_result_fifo

module fingerprint_image_scan_control
  import fingerprint_scan_pkg::*;
#(
  // Identification values are arbitrary.
  parameter logic [7:0] CHIP_ID_HIGH = 8'h5A,
  parameter logic [7:0] CHIP_ID_LOW  = 8'hA5
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [1:0]  modeSel,
  input  wire logic        regSel,
  input  wire logic        hostWrite,
  input  wire logic        hostRead,
  input  wire logic [7:0]  wrData,
  output logic      [7:0]  rdData,
  input  wire logic        adcDone,
  input  wire logic [7:0]  adcResult,
  output logic      [8:0]  rowAddr,
  output logic      [7:0]  colAddr,
  output logic             rowCapture,
  output logic             convStart,
  output logic             analogSel,
  output logic      [6:0]  drainTime,
  output logic      [4:0]  drainCurrent,
  input  wire logic        descFetch,
  input  wire logic [15:0] descAddr,
  input  wire logic [7:0]  descLen,
  output logic      [7:0]  descData,
  output logic             descValid,
  input  wire logic        misoIn,
  output logic             sck,
  output logic             serialSelect_n,
  output logic             mosi,
  output logic             internalOscOff,
  output logic             cpuBusOff,
  output logic             internalRomOff
);
  localparam logic [5:0] HALF_LAST = 6'(`SCK_HALF - 1);
  typedef struct packed {
    scan_state_t scan;
    logic [7:0]  index;
    logic        rowStartTop;
    logic [7:0]  rowStartLow;
    logic [7:0]  colFirst;
    logic        rowLastTop;
    logic [7:0]  rowLastLow;
    logic [7:0]  colLast;
    logic [6:0]  drainTime;
    logic [4:0]  drainCurrent;
    logic [3:0]  command;
    logic [1:0]  modeStrap;
    logic        strapTaken;
    logic [4:0]  pccLow;
    logic [7:0]  portOut;
    logic [7:0]  ampLevel;
    logic [7:0]  irqControl;
    logic [7:0]  irqStatus;
    logic [7:0]  fingerTrip;
    logic [7:0]  factoryTest;
    logic [7:0]  rdData;
    logic [7:0]  lastResult;
    logic        readLevel;
    logic [8:0]  rowAddr;
    logic [8:0]  rowEnd;
    logic [7:0]  colAddr;
    logic [7:0]  colStart;
    logic [7:0]  colEnd;
    logic [6:0]  drainCnt;
    logic        issued;
    logic        convStart;
    logic        rowCapture;
    logic        analogSel;
    logic        internalOscOff;
    logic        cpuBusOff;
    logic        internalRomOff;
    rom_state_t  rom;
    logic [5:0]  halfCnt;
    logic        sck;
    logic        selN;
    logic        mosi;
    logic [7:0]  shift;
    logic [2:0]  bitCnt;
    logic [8:0]  byteIdx;
    logic [8:0]  byteLast;
    logic [15:0] romAddr;
    logic [7:0]  descData;
    logic        descValid;
    logic [6:0]  lowRun;
  } ctrl_state_t;
  ctrl_state_t q;
  ctrl_state_t next_q;
  logic        readEdge;
  logic        cmdWrite;
  logic        single;
  logic        lastPixel;
  logic        converting;
  logic        fifoInValid;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;
  logic        fifoPop;
  logic [7:0]  readValue;
  logic [7:0]  nextTx;

  assign readEdge    = hostRead && !q.readLevel;
  assign cmdWrite    = hostWrite && regSel && (q.index == `IDX_CAPTURE_COMMAND);
  assign single      = (wrData[2:0] != 3'h0) && ((wrData[2:0] & (wrData[2:0] - 3'h1)) == 3'h0);
  assign lastPixel   = (q.rowAddr == q.rowEnd) && (q.colAddr == q.colEnd);
  assign converting  = (q.scan == SCAN_DRAIN) || (q.scan == SCAN_CONV);
  assign fifoInValid = (q.scan == SCAN_CONV) && q.issued && adcDone;
  assign fifoPop     = readEdge && regSel && (q.index == `IDX_CAPTURE_COMMAND);

  // Results queue here so a slow host never loses a converted pixel.
  scan_result_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) resultQueue (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (cmdWrite && single),
    .inValid  (fifoInValid),
    .inData   (adcResult),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoPop)
  );

  always_comb begin
    readValue = 8'h00;
    if (q.index == `IDX_ROW_START_HIGH) begin
      readValue = {7'h00, q.rowStartTop};
    end else if (q.index == `IDX_ROW_START_LOW) begin
      readValue = q.rowStartLow;
    end else if (q.index == `IDX_COL_FIRST) begin
      readValue = q.colFirst;
    end else if (q.index == `IDX_ROW_LAST_HIGH) begin
      readValue = {7'h00, q.rowLastTop};
    end else if (q.index == `IDX_ROW_LAST_LOW) begin
      readValue = q.rowLastLow;
    end else if (q.index == `IDX_COL_LAST) begin
      readValue = q.colLast;
    end else if (q.index == `IDX_DRAIN_TIME) begin
      readValue = {1'b0, q.drainTime};
    end else if (q.index == `IDX_DRAIN_CURRENT) begin
      readValue = {3'h0, q.drainCurrent};
    end else if (q.index == `IDX_CAPTURE_COMMAND) begin
      readValue = fifoOutValid ? fifoOutData : q.lastResult;
    end else if (q.index == `IDX_POWER_CLOCK) begin
      readValue = {q.modeStrap, !converting, q.pccLow};
    end else if (q.index == `IDX_PORT_OUT) begin
      readValue = q.portOut;
    end else if (q.index == `IDX_CAPTURE_STATUS) begin
      readValue = {4'h0, q.command};
    end else if (q.index == `IDX_AMP_LEVEL) begin
      readValue = q.ampLevel;
    end else if (q.index == `IDX_IRQ_CONTROL) begin
      readValue = q.irqControl;
    end else if (q.index == `IDX_IRQ_STATUS) begin
      readValue = q.irqStatus;
    end else if (q.index == `IDX_FINGER_TRIP) begin
      readValue = q.fingerTrip;
    end else if (q.index == `IDX_CHIP_ID_HIGH) begin
      readValue = CHIP_ID_HIGH;
    end else if (q.index == `IDX_CHIP_ID_LOW) begin
      readValue = CHIP_ID_LOW;
    end else if (q.index == `IDX_FACTORY_TEST) begin
      readValue = q.factoryTest;
    end
  end

  always_comb begin
    next_q            = q;
    next_q.convStart  = 1'b0;
    next_q.rowCapture = 1'b0;
    next_q.descValid  = 1'b0;
    next_q.readLevel  = hostRead;
    next_q.lowRun     = q.sck ? 7'h00 : q.lowRun + 7'h01;
    nextTx            = 8'h00;
    // The strap is caught on the first edge after reset release, never inside the reset.
    if (!q.strapTaken) begin
      next_q.modeStrap  = modeSel;
      next_q.strapTaken = 1'b1;
    end
    next_q.internalOscOff = q.strapTaken && (q.modeStrap == `MODE_USB_EXT_ROM);
    next_q.cpuBusOff      = q.strapTaken && (q.modeStrap == `MODE_USB_EXT_ROM);
    next_q.internalRomOff = q.strapTaken && (q.modeStrap == `MODE_USB_EXT_ROM);
    if (readEdge) begin
      next_q.rdData = regSel ? readValue : q.index;
    end
    if (fifoPop && fifoOutValid) begin
      next_q.lastResult = fifoOutData;
    end
    if (hostWrite && !regSel) begin
      next_q.index = wrData;
    end else if (hostWrite) begin
      if (q.index == `IDX_ROW_START_HIGH) begin
        next_q.rowStartTop = wrData[0];
      end else if (q.index == `IDX_ROW_START_LOW) begin
        next_q.rowStartLow = wrData;
      end else if (q.index == `IDX_COL_FIRST) begin
        next_q.colFirst = wrData;
      end else if (q.index == `IDX_ROW_LAST_HIGH) begin
        next_q.rowLastTop = wrData[0];
      end else if (q.index == `IDX_ROW_LAST_LOW) begin
        next_q.rowLastLow = wrData;
      end else if (q.index == `IDX_COL_LAST) begin
        next_q.colLast = wrData;
      end else if (q.index == `IDX_DRAIN_TIME) begin
        next_q.drainTime = wrData[6:0];
      end else if (q.index == `IDX_DRAIN_CURRENT) begin
        next_q.drainCurrent = wrData[4:0];
      end else if (q.index == `IDX_POWER_CLOCK) begin
        next_q.pccLow = wrData[4:0];
      end else if (q.index == `IDX_PORT_OUT) begin
        next_q.portOut = wrData;
      end else if (q.index == `IDX_AMP_LEVEL) begin
        next_q.ampLevel = wrData;
      end else if (q.index == `IDX_IRQ_CONTROL) begin
        next_q.irqControl = wrData;
      end else if (q.index == `IDX_IRQ_STATUS) begin
        next_q.irqStatus = wrData;
      end else if (q.index == `IDX_FINGER_TRIP) begin
        next_q.fingerTrip = wrData;
      end else if (q.index == `IDX_FACTORY_TEST) begin
        next_q.factoryTest = wrData;
      end
    end

    case (q.scan)
      SCAN_DRAIN: begin
        if (q.drainCnt == 7'h00) begin
          next_q.scan   = SCAN_CONV;
          next_q.issued = 1'b0;
        end else begin
          next_q.drainCnt = q.drainCnt - 7'h01;
        end
      end
      SCAN_CONV: begin
        // Holding the start while the queue is full keeps back-pressure on the converter.
        if (!q.issued && fifoInReady) begin
          next_q.convStart = 1'b1;
          next_q.issued    = 1'b1;
        end else if (fifoInValid) begin
          next_q.scan = SCAN_HOLD;
        end
      end
      SCAN_HOLD: begin
        if (fifoPop) begin
          next_q.scan   = SCAN_CONV;
          next_q.issued = 1'b0;
          if (q.pccLow[`PCC_AUTO_BIT]) begin
            if (lastPixel) begin
              next_q.scan = SCAN_IDLE;
            end else if (q.colAddr == q.colEnd) begin
              next_q.colAddr    = q.colStart;
              next_q.rowAddr    = q.rowAddr + 9'h001;
              next_q.rowCapture = 1'b1;
            end else begin
              next_q.colAddr = q.colAddr + 8'h01;
            end
          end
        end
      end
      default: begin
      end
    endcase

    if (cmdWrite) begin
      if (single) begin
        next_q.command    = wrData[3:0];
        next_q.analogSel  = wrData[`CMD_AIN_BIT];
        next_q.scan       = SCAN_DRAIN;
        next_q.drainCnt   = q.drainTime;
        next_q.issued     = 1'b0;
        next_q.rowCapture = 1'b1;
        next_q.rowAddr    = {q.rowStartTop, q.rowStartLow};
        next_q.rowEnd     = {q.rowStartTop, q.rowStartLow};
        next_q.colAddr    = 8'h00;
        next_q.colStart   = 8'h00;
        next_q.colEnd     = `IMG_COL_LAST;
        if (wrData[`CMD_FULL_BIT]) begin
          next_q.rowAddr = 9'h000;
          next_q.rowEnd  = `IMG_ROW_LAST;
        end else if (wrData[`CMD_WINDOW_BIT]) begin
          next_q.rowEnd   = {q.rowLastTop, q.rowLastLow};
          next_q.colAddr  = q.colFirst;
          next_q.colStart = q.colFirst;
          next_q.colEnd   = q.colLast;
        end
      end else if (wrData[2:0] == 3'h0) begin
        next_q.command[`CMD_AIN_BIT] = 1'b0;
        next_q.analogSel             = 1'b0;
      end
    end

    case (q.rom)
      ROM_IDLE: begin
        if (descFetch && q.internalRomOff) begin
          next_q.rom      = ROM_XFER;
          next_q.selN     = 1'b0;
          next_q.shift    = `ROM_READ_CMD;
          next_q.bitCnt   = 3'h0;
          next_q.byteIdx  = 9'h000;
          next_q.byteLast = `ROM_HEADER_LAST + {1'b0, descLen};
          next_q.romAddr  = descAddr;
          next_q.halfCnt  = HALF_LAST;
        end
      end
      ROM_XFER: begin
        if (q.halfCnt != 6'h00) begin
          next_q.halfCnt = q.halfCnt - 6'h01;
        end else begin
          next_q.halfCnt = HALF_LAST;
          if (q.sck) begin
            next_q.sck  = 1'b0;
            next_q.mosi = q.shift[7];
          end else begin
            next_q.sck    = 1'b1;
            next_q.shift  = {q.shift[6:0], misoIn};
            next_q.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == 3'h7) begin
              if (q.byteIdx > `ROM_HEADER_LAST) begin
                next_q.descData  = {q.shift[6:0], misoIn};
                next_q.descValid = 1'b1;
              end
              if (q.byteIdx == q.byteLast) begin
                next_q.rom  = ROM_IDLE;
                next_q.selN = 1'b1;
              end else begin
                if (q.byteIdx == 9'h000) begin
                  nextTx = q.romAddr[15:8];
                end else if (q.byteIdx == 9'h001) begin
                  nextTx = q.romAddr[7:0];
                end
                next_q.byteIdx = q.byteIdx + 9'h001;
                next_q.shift   = nextTx;
              end
            end
          end
        end
      end
      default: begin
        next_q.rom = ROM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.scan <= SCAN_IDLE;
      q.rom  <= ROM_IDLE;
      q.sck  <= 1'b1;
      q.selN <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign rdData         = q.rdData;
  assign rowAddr        = q.rowAddr;
  assign colAddr        = q.colAddr;
  assign rowCapture     = q.rowCapture;
  assign convStart      = q.convStart;
  assign analogSel      = q.analogSel;
  assign drainTime      = q.drainTime;
  assign drainCurrent   = q.drainCurrent;
  assign descData       = q.descData;
  assign descValid      = q.descValid;
  assign sck            = q.sck;
  assign serialSelect_n = q.selN;
  assign mosi           = q.mosi;
  assign internalOscOff = q.internalOscOff;
  assign cpuBusOff      = q.cpuBusOff;
  assign internalRomOff = q.internalRomOff;

  property p_romIdleHigh;
    @(posedge clock) disable iff (!rst_n) (q.rom == ROM_IDLE) |-> (q.sck && q.selN);
  endproperty
  a_romIdleHigh: assert property (p_romIdleHigh) else $error("serial clock not idle high");

  property p_sckLow;
    @(posedge clock) disable iff (!rst_n) $rose(q.sck) |-> (q.lowRun == 7'(`SCK_HALF));
  endproperty
  a_sckLow: assert property (p_sckLow) else $error("serial clock low phase too short");

  property p_mosiFalling;
    @(posedge clock) disable iff (!rst_n)
      (!q.selN && !$past(q.selN) && !$fell(q.sck)) |-> $stable(q.mosi);
  endproperty
  a_mosiFalling: assert property (p_mosiFalling) else $error("data moved off falling edge");

  property p_multiStart;
    @(posedge clock) disable iff (!rst_n)
      (cmdWrite && !single && (wrData[2:0] != 3'h0) && !readEdge)
        |=> (!q.rowCapture && $stable(q.rowAddr) && $stable(q.colAddr));
  endproperty
  a_multiStart: assert property (p_multiStart) else $error("scan started on bad command");

  property p_zeroWrite;
    @(posedge clock) disable iff (!rst_n)
      (cmdWrite && (wrData[2:0] == 3'h0) && !readEdge)
        |=> (!q.analogSel && $stable(q.rowAddr) && $stable(q.colAddr));
  endproperty
  a_zeroWrite: assert property (p_zeroWrite) else $error("zero command disturbed scan");

  property p_fullStart;
    @(posedge clock) disable iff (!rst_n) (cmdWrite && (wrData[2:0] == 3'h2))
      |=> (q.rowAddr == 9'h000 && q.colAddr == 8'h00 && q.rowEnd == `IMG_ROW_LAST
           && q.colEnd == `IMG_COL_LAST && q.rowCapture ##1 q.scan != SCAN_IDLE);
  endproperty
  a_fullStart: assert property (p_fullStart) else $error("full scan bounds wrong");

  property p_lineStart;
    @(posedge clock) disable iff (!rst_n) (cmdWrite && (wrData[2:0] == 3'h1))
      |=> (q.rowAddr == {$past(q.rowStartTop), $past(q.rowStartLow)} && q.colAddr == 8'h00);
  endproperty
  a_lineStart: assert property (p_lineStart) else $error("line scan start wrong");

  property p_windowStart;
    @(posedge clock) disable iff (!rst_n) (cmdWrite && (wrData[2:0] == 3'h4))
      |=> (q.colAddr == $past(q.colFirst) && q.colEnd == $past(q.colLast) && q.scan == SCAN_DRAIN);
  endproperty
  a_windowStart: assert property (p_windowStart) else $error("window scan start wrong");

  property p_finish;
    @(posedge clock) disable iff (!rst_n)
      (q.scan == SCAN_HOLD && fifoPop && lastPixel && q.pccLow[`PCC_AUTO_BIT] && !cmdWrite)
        |=> (q.scan == SCAN_IDLE) ##1 !q.convStart;
  endproperty
  a_finish: assert property (p_finish) else $error("scan ran past its last pixel");

  property p_readyBit;
    @(posedge clock) disable iff (!rst_n)
      (readEdge && regSel && q.index == `IDX_POWER_CLOCK)
        |=> (q.rdData[`PCC_READY_BIT] == ($past(q.scan) == SCAN_IDLE || $past(q.scan) == SCAN_HOLD));
  endproperty
  a_readyBit: assert property (p_readyBit) else $error("ready bit wrong");

  property p_romMode;
    @(posedge clock) disable iff (!rst_n) ($past(q.strapTaken) && q.modeStrap == `MODE_USB_EXT_ROM)
      |-> (q.internalOscOff && q.cpuBusOff && q.internalRomOff);
  endproperty
  a_romMode: assert property (p_romMode) else $error("external rom mode not applied");
endmodule : fingerprint_image_scan_control

/* scan_adc_model.sv */
module scan_adc_model #(
  parameter int LAT = 3
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       convStart,
  input  wire logic [8:0] rowAddr,
  input  wire logic [7:0] colAddr,
  output logic            adcDone,
  output logic      [7:0] adcResult
);
  logic [3:0] cnt;
  // The result bus toggles between conversions so a stale value is never mistaken for data.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      adcDone <= 1'b0;
      adcResult <= 8'h00;
    end else begin
      adcDone <= (cnt == 4'h1);
      adcResult <= (cnt == 4'h1) ? (colAddr ^ rowAddr[7:0]) : ~adcResult;
      if (convStart) cnt <= 4'(LAT);
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule : scan_adc_model

module serial_rom_model #(
  parameter logic [7:0] DATA = 8'hC6
) (
  input  wire logic        clock,
  input  wire logic        sck,
  input  wire logic        selN,
  input  wire logic        mosi,
  output logic             miso,
  output logic      [31:0] seenBits
);
  logic       sckSeen;
  logic [2:0] bitIdx;
  // The pin keeper holds the last driven level, so the line is never floated between frames.
  initial begin
    miso     = 1'b1;
    seenBits = 32'h0;
    sckSeen  = 1'b1;
    bitIdx   = 3'h7;
  end
  // Edges of the serial clock are seen at the falling system edge, away from the sampling edge.
  always @(negedge clock) begin
    if (!selN && sckSeen && !sck) begin
      miso   <= DATA[bitIdx];
      bitIdx <= bitIdx - 3'h1;
    end
    if (!sckSeen && sck) begin
      seenBits <= {seenBits[30:0], mosi};
    end
    sckSeen <= sck;
  end
endmodule : serial_rom_model

/* fingerprint_image_scan_control_tb_top.sv */
module fingerprint_image_scan_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, regSel = 0, hostWrite = 0, hostRead = 0;
  logic [7:0] wrData = 8'h00, rdData, colAddr, adcResult;
  logic [8:0] rowAddr;
  logic [6:0] drainTime;
  logic adcDone, convStart, analogSel, sck, selN, romOff, oscOff, busOff;
  int mismatches = 0, n_compared = 0, cycles = 0;
  logic [7:0] d;
  bit got;
  logic descFetch = 0, miso, mosi, descValid;
  logic [7:0] descData;
  logic [1:0] modeSel = 2'h3;
  logic [31:0] romBits;
  fingerprint_image_scan_control DUT (.clock(clock), .rst_n(rst_n), .modeSel(modeSel),
    .regSel(regSel), .hostWrite(hostWrite), .hostRead(hostRead), .wrData(wrData),
    .rdData(rdData), .adcDone(adcDone), .adcResult(adcResult), .rowAddr(rowAddr),
    .colAddr(colAddr), .rowCapture(), .convStart(convStart), .analogSel(analogSel),
    .drainTime(drainTime), .drainCurrent(), .descFetch(descFetch), .descAddr(16'h1234),
    .descLen(8'h01), .descData(descData), .descValid(descValid), .misoIn(miso), .sck(sck),
    .serialSelect_n(selN), .mosi(mosi), .internalOscOff(oscOff), .cpuBusOff(busOff),
    .internalRomOff(romOff));
  serial_rom_model rom (.clock(clock), .sck(sck), .selN(selN), .mosi(mosi), .miso(miso),
    .seenBits(romBits));
  scan_adc_model adc (.clock(clock), .rst_n(rst_n), .convStart(convStart),
    .rowAddr(rowAddr), .colAddr(colAddr), .adcDone(adcDone), .adcResult(adcResult));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic s, input logic [7:0] v);
    @(negedge clock) {regSel, wrData, hostWrite} = {s, v, 1'b1};
    @(negedge clock) hostWrite = 0;
  endtask : wr
  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    wr(0, i);
    wr(1, v);
  endtask : wreg
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    wr(0, i);
    {regSel, hostRead} = 2'b11;
    @(negedge clock) hostRead = 0;
    @(negedge clock) v = rdData;
  endtask : rd
  // Watches convStart (which=0) or adcDone (which=1) for a bounded number of cycles.
  task automatic seen(input int lim, input bit which, output bit g);
    g = 0;
    repeat (lim) begin
      @(posedge clock) #1;
      if ((which ? adcDone : convStart) === 1'b1) begin
        g = 1;
        break;
      end
    end
  endtask : seen
  task automatic go(input logic [7:0] c, input logic [8:0] r, input logic [7:0] col);
    wreg(8'h08, c);
    seen(30, 0, got);
    cmp(got, 1);
    cmp(rowAddr, r);
    cmp(colAddr, col);
  endtask : go
  task automatic test_regs();
    rd(8'h09, d); cmp(d, 8'hE0);
    wreg(8'h10, 8'h00); rd(8'h10, d); cmp(d, 8'h5A);
    wreg(8'h00, 8'hFF); rd(8'h00, d); cmp(d, 8'h01);
    wreg(8'h06, 8'hFF); rd(8'h06, d); cmp(d, 8'h7F);
    cmp({2'b0, drainTime}, 9'h07F);
    wreg(8'h07, 8'hFF); rd(8'h07, d); cmp(d, 8'h1F);
    cmp({sck, selN}, 2'h3);
    cmp({romOff, oscOff, busOff}, 3'h7);
    $display("regs test done");
  endtask : test_regs
  task automatic test_window();
    wreg(8'h00, 8'h00); wreg(8'h01, 8'h05); wreg(8'h02, 8'hFE);
    wreg(8'h03, 8'h00); wreg(8'h04, 8'h06); wreg(8'h05, 8'hFF);
    wreg(8'h06, 8'h02); wreg(8'h09, 8'h04);
    go(8'h04, 9'h005, 8'hFE);
    for (int k = 0; k < 4; k++) begin
      seen(6, 1, got); cmp(got, 1);
      rd(8'h08, d);
      cmp(d, (8'hFE + 8'(k % 2)) ^ (8'h05 + 8'(k / 2)));
    end
    seen(40, 0, got); cmp(got, 0);
    wreg(8'h08, 8'h03); seen(40, 0, got); cmp(got, 0);
    $display("window test done");
  endtask : test_window
  task automatic test_modes();
    go(8'h02, 9'h000, 8'h00);
    rd(8'h09, d); cmp(d, 8'hC4);
    go(8'h09, 9'h005, 8'h00);
    cmp(analogSel, 1);
    wreg(8'h08, 8'h00);
    @(negedge clock) cmp(analogSel, 0);
    $display("modes test done");
  endtask : test_modes
  // A 1 MHz ceiling means at least 125 cycles per bit over the 32 bits of the frame.
  task automatic test_rom();
    int low;
    low = 0;
    got = 0;
    @(negedge clock) descFetch = 1;
    @(negedge clock) descFetch = 0;
    repeat (4100) begin
      @(posedge clock) #1;
      if (selN === 1'b0) low++;
      if (descValid === 1'b1) begin
        got = 1;
        cmp(descData, 8'hC6);
      end
    end
    cmp(got, 1);
    cmp(low >= 4000, 1);
    cmp({sck, selN}, 2'h3);
    cmp(romBits[31:24], 8'h03);
    cmp(romBits[23:16], 8'h12);
    cmp(romBits[15:8], 8'h34);
    $display("rom test done");
  endtask : test_rom
  task automatic test_strap();
    @(negedge clock) {modeSel, rst_n} = 3'b000;
    repeat (2) @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    rd(8'h09, d); cmp(d, 8'h20);
    cmp({romOff, oscOff, busOff}, 3'h0);
    $display("strap test done");
  endtask : test_strap
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    test_regs();
    test_window();
    test_modes();
    test_rom();
    test_strap();
    stop_test();
  end
endmodule : fingerprint_image_scan_control_tb_top
